// ---- verilog/dps_regs.svh ----
`ifndef DPS_REGS_SVH
`define DPS_REGS_SVH
// parallel role codes
`define DPS_ROLE_SINGLE        3'h0
`define DPS_ROLE_LEADER        3'h3
`define DPS_ROLE_FOLLOWER      3'h4
// response codes
`define DPS_RESP_NONE          2'h0
`define DPS_RESP_WARN          2'h1
`define DPS_RESP_FAULT         2'h2
`define DPS_RESP_COAST         2'h3
// quick stop indication codes
`define DPS_QS_WARN            2'h1
`define DPS_QS_FAULT           2'h2
// alarm output styles
`define DPS_STYLE_STATIC       2'h0
`define DPS_STYLE_TOGGLE       2'h1
`define DPS_STYLE_LATCH        2'h2
// timing: tick of 1 ms from 100 ns clock
`define DPS_TICK_NS            1000000
`define DPS_CLK_NS             100
`define DPS_TICK_CYCLES        (`DPS_TICK_NS / `DPS_CLK_NS)
`define DPS_PULSE_MS           1000
`define DPS_LZ_SLOW_MS         5000
`define DPS_LZ_FAST_MS         500
// analogue limits: ua, 0.01 % units
`define DPS_LZ_SLOW_UA         16'd3500
`define DPS_LZ_FAST_UA         16'd500
`define DPS_LZ_MIN_PCT         16'd1600
// encoder gating: 0.01 Hz and 0.1 % units
`define DPS_ENC_REF_CHZ        16'd100
`define DPS_ENC_TRQ_PMIL       16'd1000
// temperature stand-ins, signed 0.1 degC
`define DPS_TEMP_ABSENT        16'sd2000
`define DPS_TEMP_SHORT         -16'sd300
// fault codes
`define DPS_FCODE_CONTACTOR    8'h40
`endif

// ---- verilog/dps_pkg.sv ----
package dps_pkg;
   typedef logic [1:0] dps_resp_t;
   typedef logic [2:0] dps_role_t;
   typedef logic [2:0] dps_chsel_t;
   typedef enum logic [1:0] {
      DPS_CT_OPEN  = 2'b00,
      DPS_CT_WAIT  = 2'b01,
      DPS_CT_HELD  = 2'b10,
      DPS_CT_FAIL  = 2'b11
   } dps_ct_state_t;
endpackage

// ---- verilog/dps_timer.sv ----
`timescale 1ns/10ps
`default_nettype none
// counts ticks while cond holds; restarts when cond clears
module dps_timer #(
   parameter int W = 16
) (
   input  wire logic         sys_clk,
   input  wire logic         rst_n,
   input  wire logic         tick,
   input  wire logic         cond,
   input  wire logic [W-1:0] limit,
   output logic              expired
);
   logic [W-1:0] cnt_q;

   initial begin
      if (W < 2) $error("dps_timer width too small");
   end

   // tick counter, cleared when condition drops
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else if (!cond) begin
         cnt_q <= '0;
      end else if (tick && cnt_q < limit) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   assign expired = cond && (cnt_q >= limit);
endmodule
`default_nettype wire

// ---- verilog/dps_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
// two-flop synchroniser for pin inputs
module dps_sync #(
   parameter int W = 1
) (
   input  wire logic         sys_clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] s1_q;

   initial begin
      if (W < 1) $error("dps_sync width must be positive");
   end

   // first stage feeds only the second
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= '0;
         q    <= '0;
      end else begin
         s1_q <= d;
         q    <= s1_q;
      end
   end
endmodule
`default_nettype wire

// ---- verilog/dps_supervisor.sv ----
`include "dps_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module dps_supervisor #(
   parameter int TICK_CYCLES = `DPS_TICK_CYCLES,
   parameter int TW          = 16
) (
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   // configuration
   input  wire dps_pkg::dps_role_t  parallel_role_select,
   input  wire dps_pkg::dps_resp_t  thermistor_resp,
   input  wire logic [TW-1:0]     coolant_loss_delay,
   input  wire dps_pkg::dps_resp_t  filter_temp_resp,
   input  wire logic [TW-1:0]     max_charge_time,
   input  wire logic              contactor_on_fault,
   input  wire logic [TW-1:0]     start_fault_delay,
   input  wire logic [1:0]        quick_stop_resp,
   input  wire logic signed [15:0] reactive_trip_limit,
   input  wire logic [TW-1:0]     contactor_ack_delay,
   input  wire dps_pkg::dps_resp_t  phase_loss_resp,
   input  wire logic [15:0]       ain_min_pct,
   input  wire dps_pkg::dps_resp_t  live_zero_resp,
   input  wire dps_pkg::dps_resp_t  encoder_resp,
   input  wire logic [1:0]        alarm_output_style,
   input  wire dps_pkg::dps_chsel_t temp_card1_inputs,
   input  wire dps_pkg::dps_resp_t  temp_resp,
   input  wire logic signed [15:0] temp_warn_limit,
   input  wire logic signed [15:0] temp_fault_limit,
   input  wire logic signed [15:0] temp_bus_value,
   input  wire logic              status_reset,
   // drive state and measurements (same clock)
   input  wire logic              run_cmd,
   input  wire logic              charging_active,
   input  wire logic              peer_running,
   input  wire logic signed [15:0] reactive_current,
   input  wire logic [15:0]       ain1_ua,
   input  wire logic [15:0]       ain2_ua,
   input  wire logic [15:0]       speed_ref_chz,
   input  wire logic [15:0]       torque_avail_pmil,
   input  wire logic [2:0]        temp_present,
   input  wire logic [2:0]        temp_short,
   input  wire logic signed [15:0] temp_ch0,
   input  wire logic signed [15:0] temp_ch1,
   input  wire logic signed [15:0] temp_ch2,
   // pins from outside
   input  wire logic              thermistor_trip_pin,
   input  wire logic              coolant_ok_pin,
   input  wire logic              filter_hot_pin,
   input  wire logic              quick_stop_pin,
   input  wire logic              phase_loss_pin,
   input  wire logic              contactor_ack_pin,
   input  wire logic              encoder_pulse_pin,
   // outputs
   output logic                   sync_leader_inverter,
   output logic                   sync_follower_inverter,
   output logic                   d2d_bus_enable,
   output logic                   contactor_close,
   output logic                   fault_active,
   output logic                   warning_active,
   output logic                   coast_stop,
   output logic                   ramp_stop,
   output logic                   open_loop_fallback,
   output logic                   alarm_out,
   output logic [7:0]             fault_code,
   output logic signed [15:0]     temp_max
);
   import dps_pkg::*;

   localparam int CW = $clog2(TICK_CYCLES + 1);
   localparam logic [TW-1:0] PULSE_T   = TW'(`DPS_PULSE_MS);
   localparam logic [TW-1:0] LZ_SLOW_T = TW'(`DPS_LZ_SLOW_MS);
   localparam logic [TW-1:0] LZ_FAST_T = TW'(`DPS_LZ_FAST_MS);
   localparam logic [TW-1:0] ENC_T     = TW'(`DPS_PULSE_MS);

   initial begin
      if (TICK_CYCLES < 1) $error("TICK_CYCLES must be at least 1");
      if (TW < 13) $error("TW too narrow for fixed timers");
   end

   // response decode: bit0 warn, bit1 fault, bit2 coast
   function automatic logic [2:0] resp_eval(input logic hit, input dps_resp_t r);
      logic [2:0] o;
      o = 3'b000;
      if (hit) begin
         unique case (r)
            `DPS_RESP_NONE:  o = 3'b000;
            `DPS_RESP_WARN:  o = 3'b001;
            `DPS_RESP_FAULT: o = 3'b010;
            `DPS_RESP_COAST: o = 3'b110;
         endcase
      end
      return o;
   endfunction

   // channel-set decode to mask
   function automatic logic [2:0] chan_mask(input dps_chsel_t s);
      logic [2:0] m;
      unique case (s)
         3'h1:    m = 3'b001;
         3'h2:    m = 3'b011;
         3'h3:    m = 3'b111;
         3'h4:    m = 3'b110;
         3'h5:    m = 3'b100;
         default: m = 3'b000;
      endcase
      return m;
   endfunction

   // channel value with absent/short substitution
   function automatic logic signed [15:0] chan_val(input logic pres, input logic sh,
                                                   input logic signed [15:0] v);
      logic signed [15:0] r;
      r = v;
      if (!pres) r = `DPS_TEMP_ABSENT;
      else if (sh) r = `DPS_TEMP_SHORT;
      return r;
   endfunction

   // pin synchronisers
   logic [6:0] pin_s;
   dps_sync #(.W(7)) u_sync (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .d       ({encoder_pulse_pin, contactor_ack_pin, phase_loss_pin, quick_stop_pin,
                 filter_hot_pin, ~coolant_ok_pin, thermistor_trip_pin}),
      .q       (pin_s)
   );
   wire therm_s = pin_s[0];
   wire cool_s  = ~pin_s[1]; // stored inverted so the reset value reads flow ok
   wire filt_s  = pin_s[2];
   wire qs_s    = pin_s[3];
   wire phase_s = pin_s[4];
   wire ack_s   = pin_s[5];
   wire enc_s   = pin_s[6];

   // internal tick
   logic [CW-1:0] div_q;
   logic          tick_q;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_q  <= '0;
         tick_q <= 1'b0;
      end else if (div_q == CW'(TICK_CYCLES - 1)) begin
         div_q  <= '0;
         tick_q <= 1'b1;
      end else begin
         div_q  <= div_q + 1'b1;
         tick_q <= 1'b0;
      end
   end

   // parallel role decode
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_leader_inverter   <= 1'b0;
         sync_follower_inverter <= 1'b0;
         d2d_bus_enable         <= 1'b0;
      end else begin
         sync_leader_inverter   <= parallel_role_select == `DPS_ROLE_LEADER;
         sync_follower_inverter <= parallel_role_select == `DPS_ROLE_FOLLOWER;
         d2d_bus_enable         <= parallel_role_select != `DPS_ROLE_SINGLE;
      end
   end
   wire paired = (parallel_role_select == `DPS_ROLE_LEADER) ||
                 (parallel_role_select == `DPS_ROLE_FOLLOWER);

   // contactor supervision state
   dps_ct_state_t ct_q;
   logic          any_fault;
   logic          ack_late;

   // timers
   logic cool_exp, chg_exp, start_exp, ack_exp, lz1s, lz1f, lz2s, lz2f, enc_exp;
   logic enc_seen_q, enc_prev_q;
   wire  enc_gate = run_cmd && speed_ref_chz > `DPS_ENC_REF_CHZ &&
                    torque_avail_pmil >= `DPS_ENC_TRQ_PMIL;
   wire  lz_on    = ain_min_pct > `DPS_LZ_MIN_PCT;

   dps_timer #(.W(TW)) u_cool (.sys_clk(sys_clk), .rst_n(rst_n), .tick(tick_q),
      .cond(!cool_s && run_cmd), .limit(coolant_loss_delay), .expired(cool_exp));
   dps_timer #(.W(TW)) u_chg (.sys_clk(sys_clk), .rst_n(rst_n), .tick(tick_q),
      .cond(charging_active), .limit(max_charge_time), .expired(chg_exp));
   dps_timer #(.W(TW)) u_start (.sys_clk(sys_clk), .rst_n(rst_n), .tick(tick_q),
      .cond(paired && run_cmd && !peer_running), .limit(start_fault_delay),
      .expired(start_exp));
   dps_timer #(.W(TW)) u_ack (.sys_clk(sys_clk), .rst_n(rst_n), .tick(tick_q),
      .cond(ct_q == DPS_CT_WAIT), .limit(contactor_ack_delay), .expired(ack_exp));
   dps_timer #(.W(TW)) u_lz1s (.sys_clk(sys_clk), .rst_n(rst_n), .tick(tick_q),
      .cond(lz_on && ain1_ua < `DPS_LZ_SLOW_UA), .limit(LZ_SLOW_T), .expired(lz1s));
   dps_timer #(.W(TW)) u_lz1f (.sys_clk(sys_clk), .rst_n(rst_n), .tick(tick_q),
      .cond(lz_on && ain1_ua < `DPS_LZ_FAST_UA), .limit(LZ_FAST_T), .expired(lz1f));
   dps_timer #(.W(TW)) u_lz2s (.sys_clk(sys_clk), .rst_n(rst_n), .tick(tick_q),
      .cond(lz_on && ain2_ua < `DPS_LZ_SLOW_UA), .limit(LZ_SLOW_T), .expired(lz2s));
   dps_timer #(.W(TW)) u_lz2f (.sys_clk(sys_clk), .rst_n(rst_n), .tick(tick_q),
      .cond(lz_on && ain2_ua < `DPS_LZ_FAST_UA), .limit(LZ_FAST_T), .expired(lz2f));
   dps_timer #(.W(TW)) u_enc (.sys_clk(sys_clk), .rst_n(rst_n), .tick(tick_q),
      .cond(enc_gate && !enc_seen_q), .limit(ENC_T), .expired(enc_exp));

   // encoder edge seen on the previous clock while gated; one-cycle flag that restarts the window
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         enc_prev_q <= 1'b0;
         enc_seen_q <= 1'b0;
      end else begin
         enc_prev_q <= enc_s;
         enc_seen_q <= (enc_s != enc_prev_q) && enc_gate;
      end
   end

   // contactor control sequence
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ct_q <= DPS_CT_OPEN;
      end else begin
         unique case (ct_q)
            DPS_CT_OPEN: if (run_cmd && !(any_fault && contactor_on_fault)) ct_q <= DPS_CT_WAIT;
            DPS_CT_WAIT: begin
               if (ack_s) ct_q <= DPS_CT_HELD;
               else if (ack_exp) ct_q <= DPS_CT_FAIL;
            end
            DPS_CT_HELD: if (!run_cmd && !any_fault) ct_q <= DPS_CT_OPEN;
            DPS_CT_FAIL: if (status_reset) ct_q <= DPS_CT_OPEN;
         endcase
         if (any_fault && contactor_on_fault) ct_q <= (ct_q == DPS_CT_FAIL) ? DPS_CT_FAIL
                                                                         : DPS_CT_OPEN;
      end
   end
   assign ack_late = ct_q == DPS_CT_FAIL;

   // temperature selection and maximum
   logic signed [15:0] tv0, tv1, tv2, tmax_c;
   logic [2:0]         tmask;
   always_comb begin
      tmask  = chan_mask(temp_card1_inputs);
      tv0    = chan_val(temp_present[0], temp_short[0], temp_ch0);
      tv1    = chan_val(temp_present[1], temp_short[1], temp_ch1);
      tv2    = chan_val(temp_present[2], temp_short[2], temp_ch2);
      tmax_c = `DPS_TEMP_SHORT;
      if (tmask == 3'b000) tmax_c = temp_bus_value;
      if (tmask[0] && tv0 > tmax_c) tmax_c = tv0;
      if (tmask[1] && tv1 > tmax_c) tmax_c = tv1;
      if (tmask[2] && tv2 > tmax_c) tmax_c = tv2;
   end

   // per-source response vectors
   logic [2:0] r_therm, r_cool, r_filt, r_phase, r_lz, r_enc, r_tw, r_tf, r_qs, r_fix;
   logic [2:0] r_all;
   always_comb begin
      r_therm = resp_eval(therm_s, thermistor_resp);
      r_cool  = cool_exp ? 3'b110 : ((!cool_s && !run_cmd) ? 3'b001 : 3'b000);
      if (!cool_s && run_cmd && !cool_exp) r_cool = 3'b001;
      r_filt  = resp_eval(filt_s, filter_temp_resp);
      r_phase = resp_eval(phase_s, phase_loss_resp);
      r_lz    = resp_eval(lz1s | lz1f | lz2s | lz2f,
                          (live_zero_resp == `DPS_RESP_COAST) ? `DPS_RESP_FAULT : live_zero_resp);
      r_enc   = 3'b000;
      if (enc_exp) begin
         r_enc = (encoder_resp == `DPS_RESP_FAULT) ? 3'b010 :
                 (encoder_resp == `DPS_RESP_NONE) ? 3'b000 : 3'b001;
      end
      r_tw    = resp_eval(tmax_c > temp_warn_limit,
                          (temp_resp == `DPS_RESP_NONE) ? `DPS_RESP_NONE : `DPS_RESP_WARN);
      r_tf    = resp_eval(tmax_c > temp_fault_limit, temp_resp);
      r_qs    = 3'b000;
      if (qs_s) r_qs = (quick_stop_resp == `DPS_QS_FAULT) ? 3'b010 : 3'b001;
      r_fix   = {1'b0, chg_exp | start_exp | ack_late |
                 (reactive_current < reactive_trip_limit), 1'b0};
      r_all   = r_therm | r_cool | r_filt | r_phase | r_lz | r_enc | r_tw | r_tf | r_qs | r_fix;
   end

   // latched faults, live warnings
   logic fault_q, coast_q;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         fault_q <= 1'b0;
         coast_q <= 1'b0;
      end else begin
         fault_q <= r_all[1] | (fault_q & ~status_reset); // set wins over reset
         coast_q <= r_all[2] | (coast_q & ~status_reset);
      end
   end
   assign any_fault = fault_q;

   // registered indication outputs
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         fault_active       <= 1'b0;
         warning_active     <= 1'b0;
         coast_stop         <= 1'b0;
         ramp_stop          <= 1'b0;
         open_loop_fallback <= 1'b0;
         contactor_close    <= 1'b0;
         fault_code         <= 8'h00;
         temp_max           <= 16'sh0000;
      end else begin
         fault_active       <= fault_q;
         warning_active     <= r_all[0];
         coast_stop         <= coast_q;
         ramp_stop          <= (fault_q & ~coast_q) | qs_s;
         open_loop_fallback <= enc_exp && encoder_resp == `DPS_RESP_COAST;
         contactor_close    <= ct_q != DPS_CT_OPEN && !(any_fault && contactor_on_fault);
         fault_code         <= ack_late ? `DPS_FCODE_CONTACTOR : 8'h00;
         temp_max           <= tmax_c;
      end
   end

   // alarm output styles
   wire          alarm_now = fault_q | r_all[0];
   logic         alarm_prev_q, pulse_run_q, latch_q;
   logic [TW-1:0] pulse_cnt_q;
   wire          new_alarm = alarm_now & ~alarm_prev_q;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         alarm_prev_q <= 1'b0;
         pulse_run_q  <= 1'b0;
         pulse_cnt_q  <= '0;
         latch_q      <= 1'b0;
         alarm_out    <= 1'b0;
      end else begin
         alarm_prev_q <= alarm_now;
         if (new_alarm) begin
            pulse_run_q <= 1'b1;
            pulse_cnt_q <= '0;
         end else if (pulse_run_q && tick_q) begin
            pulse_cnt_q <= pulse_cnt_q + 1'b1;
            if (pulse_cnt_q == PULSE_T - 1'b1) pulse_run_q <= 1'b0;
         end
         latch_q <= new_alarm | (latch_q & ~status_reset);
         unique case (alarm_output_style)
            `DPS_STYLE_TOGGLE: alarm_out <= pulse_run_q | new_alarm;
            `DPS_STYLE_LATCH:  alarm_out <= latch_q | new_alarm;
            default:           alarm_out <= alarm_now;
         endcase
      end
   end
endmodule
`default_nettype wire

// ---- testbench/dps_supervisor_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
// watches role, stop, contactor, alarm and temperature outputs of the supervisor
module dps_supervisor_asserts #(
   parameter int TICK_CYCLES = 10000,
   parameter int TW          = 16
) (
   input  wire logic                sys_clk,
   input  wire logic                rst_n,
   input  wire dps_pkg::dps_role_t  parallel_role_select,
   input  wire dps_pkg::dps_resp_t  encoder_resp,
   input  wire dps_pkg::dps_chsel_t temp_card1_inputs,
   input  wire logic [1:0]          alarm_output_style,
   input  wire logic                contactor_on_fault,
   input  wire logic                quick_stop_pin,
   input  wire logic signed [15:0]  temp_bus_value,
   input  wire logic                sync_leader_inverter,
   input  wire logic                sync_follower_inverter,
   input  wire logic                d2d_bus_enable,
   input  wire logic                contactor_close,
   input  wire logic                fault_active,
   input  wire logic                warning_active,
   input  wire logic                coast_stop,
   input  wire logic                ramp_stop,
   input  wire logic                open_loop_fallback,
   input  wire logic                alarm_out,
   input  wire logic [7:0]          fault_code,
   input  wire logic signed [15:0]  temp_max
);
   import dps_pkg::*;
   logic [1:0] up_q;
   logic       ok;
   // counts edges since reset so that outputs still held low are skipped
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         up_q <= 2'h0;
      end else if (up_q != 2'h3) begin
         up_q <= up_q + 2'h1;
      end
   end
   assign ok = (up_q == 2'h3);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   a_role_leader: assert property (ok |=> sync_leader_inverter == ($past(parallel_role_select) == 3'h3))
      else $error("leader flag does not follow role");
   a_role_follower: assert property (ok |=> sync_follower_inverter == ($past(parallel_role_select) == 3'h4))
      else $error("follower flag does not follow role");
   a_bus_off: assert property (ok && parallel_role_select == 3'h0 |=> !d2d_bus_enable)
      else $error("link bus on in single role");
   a_qs_stop: assert property (ok && $rose(quick_stop_pin) |-> ##[1:5] (ramp_stop || coast_stop))
      else $error("quick stop did not stop");
   a_mcc_open: assert property (ok && fault_active && contactor_on_fault |-> ##[0:2] !contactor_close)
      else $error("contactor left closed on fault");
   a_alarm_static: assert property ((ok && alarm_output_style == 2'h0 && (fault_active || warning_active)) [*2]
      |-> ##[0:2] alarm_out)
      else $error("static alarm output low");
   a_fcode_value: assert property (fault_code != 8'h00 |-> fault_code == 8'h40)
      else $error("unexpected fault code");
   a_ack_fault: assert property (ok && $rose(fault_code == 8'h40) |-> ##[0:3] fault_active)
      else $error("contactor fault code without fault");
   a_open_loop: assert property (open_loop_fallback |-> encoder_resp == 2'h3)
      else $error("open loop fallback with wrong response");
   a_temp_bus: assert property (ok && temp_card1_inputs == 3'h0 |=> temp_max == $past(temp_bus_value))
      else $error("bus temperature not passed through");
   c_open_loop: cover property (ok && open_loop_fallback);
   c_ack_fault: cover property (fault_code == 8'h40);
   c_alarm_latch: cover property (alarm_output_style == 2'h2 && alarm_out);
endmodule
bind dps_supervisor dps_supervisor_asserts #(.TICK_CYCLES(TICK_CYCLES), .TW(TW)) i_dps_supervisor_asserts (.*);
`default_nettype wire

// ---- testbench/dps_contactor_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// main contactor: acknowledge follows the close command after a mechanical lag
module dps_contactor_model (
   input  wire logic sys_clk,
   input  wire logic contactor_close,
   input  wire logic ack_en,
   output logic      contactor_ack_pin
);
   logic [3:0] lag_q;
   // a broken unit (ack_en low) never answers
   always_ff @(posedge sys_clk) begin
      lag_q <= contactor_close ? lag_q + ((lag_q != 4'hf) ? 4'h1 : 4'h0) : 4'h0;
      contactor_ack_pin <= ack_en && (lag_q == 4'hf);
   end
endmodule
`default_nettype wire

// ---- testbench/dps_supervisor_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; $display("ERROR %0t got %h exp %h", $time, a, e); end end
module dps_supervisor_tb;
   import dps_pkg::*;
   logic               sys_clk = 1'b0, rst_n = 1'b0, contactor_on_fault = 1'b0, status_reset = 1'b0;
   logic               run_cmd = 1'b0, charging_active = 1'b0, peer_running = 1'b0, ack_en = 1'b1;
   logic               thermistor_trip_pin = 1'b0, coolant_ok_pin = 1'b1, filter_hot_pin = 1'b0;
   logic               quick_stop_pin = 1'b0, phase_loss_pin = 1'b0, encoder_pulse_pin = 1'b0;
   logic               contactor_ack_pin;
   dps_role_t          parallel_role_select = 3'h0;
   dps_chsel_t         temp_card1_inputs = 3'h0;
   dps_resp_t          thermistor_resp = 2'h0, filter_temp_resp = 2'h0, phase_loss_resp = 2'h0;
   dps_resp_t          live_zero_resp = 2'h2, encoder_resp = 2'h0, temp_resp = 2'h0;
   logic [1:0]         quick_stop_resp = 2'h1, alarm_output_style = 2'h0;
   logic [15:0]        coolant_loss_delay = 16'h3, max_charge_time = 16'h3, start_fault_delay = 16'h3;
   logic [15:0]        contactor_ack_delay = 16'h3, ain_min_pct = 16'h0, ain1_ua = 16'h2710;
   logic [15:0]        ain2_ua = 16'h2710, speed_ref_chz = 16'h0, torque_avail_pmil = 16'h0;
   logic [2:0]         temp_present = 3'h7, temp_short = 3'h0;
   logic signed [15:0] reactive_trip_limit = -16'sh3e8, reactive_current = 16'sh0, temp_warn_limit = 16'sh3e8;
   logic signed [15:0] temp_fault_limit = 16'sh3e8, temp_bus_value = 16'sh64, temp_ch0 = 16'sh190;
   logic signed [15:0] temp_ch1 = 16'sh12c, temp_ch2 = 16'shc8, temp_max;
   logic               sync_leader_inverter, sync_follower_inverter, d2d_bus_enable, contactor_close;
   logic               fault_active, warning_active, coast_stop, ramp_stop, open_loop_fallback, alarm_out;
   logic [7:0]         fault_code;
   dps_role_t          roles[3] = '{3'h0, 3'h3, 3'h4};
   logic signed [15:0] tmx[6] = '{16'sh64, 16'sh190, 16'sh190, 16'sh190, 16'sh12c, 16'shc8};
   int                 bad_count = 0;
   int                 num_checks = 0;

   dps_supervisor #(.TICK_CYCLES(10)) i_dps_supervisor (.*);
   dps_contactor_model i_dps_contactor_model (.sys_clk(sys_clk), .contactor_close(contactor_close),
                                              .ack_en(ack_en), .contactor_ack_pin(contactor_ack_pin));

   // 10 MHz clock
   initial begin
      forever #50 sys_clk = ~sys_clk;
   end

   // waits n edges, then steps just past the edge
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic rst();
      rst_n = 1'b0;
      cyc(2);
      rst_n = 1'b1;
   endtask

   task automatic close_out();
      $display("checks %0d errors %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // cuts a hang short
   initial begin
      #7000000;
      bad_count++;
      close_out();
   end

   // test sequence
   initial begin
      cyc(8);
      rst_n = 1'b1;
      for (int i = 0; i < 3; i++) begin
         parallel_role_select = roles[i];
         cyc(3);
         `CHK(sync_leader_inverter, i == 1)
         `CHK(sync_follower_inverter, i == 2)
         `CHK(d2d_bus_enable, i != 0)
      end
      rst();
      run_cmd = 1'b1;
      cyc(80);
      `CHK(fault_active, 1'b1)
      parallel_role_select = 3'h0;
      rst();
      cyc(80);
      `CHK(contactor_close, 1'b1)
      `CHK(fault_active, 1'b0)
      ack_en = 1'b0;
      rst();
      cyc(80);
      `CHK(fault_code, 8'h40)
      `CHK(contactor_close, 1'b1)
      contactor_on_fault = 1'b1;
      cyc(4);
      `CHK(contactor_close, 1'b0)
      ack_en = 1'b1;
      contactor_on_fault = 1'b0;
      run_cmd = 1'b0;
      rst();
      coolant_ok_pin = 1'b0;
      cyc(80);
      `CHK(warning_active, 1'b1)
      `CHK(fault_active, 1'b0)
      run_cmd = 1'b1;
      cyc(15);
      `CHK(fault_active, 1'b0)
      cyc(60);
      `CHK(fault_active, 1'b1)
      `CHK(coast_stop, 1'b1)
      coolant_ok_pin = 1'b1;
      run_cmd = 1'b0;
      for (int k = 0; k < 3; k++) begin
         for (int r = 0; r < 4; r++) begin
            rst();
            thermistor_resp = (k == 0) ? r[1:0] : 2'h0;
            filter_temp_resp = (k == 1) ? r[1:0] : 2'h0;
            phase_loss_resp = (k == 2) ? r[1:0] : 2'h0;
            thermistor_trip_pin = (k == 0);
            filter_hot_pin = (k == 1);
            phase_loss_pin = (k == 2);
            cyc(8);
            `CHK(warning_active, r == 1)
            `CHK(fault_active, r > 1)
            `CHK(coast_stop, r == 3)
            `CHK(alarm_out, r != 0)
         end
      end
      phase_loss_pin = 1'b0;
      for (int q = 1; q < 3; q++) begin
         rst();
         quick_stop_resp = q[1:0];
         cyc(3);
         quick_stop_pin = 1'b1;
         cyc(8);
         `CHK(ramp_stop | coast_stop, 1'b1)
         `CHK(fault_active, q == 2)
         quick_stop_pin = 1'b0;
      end
      rst();
      reactive_current = -16'sh3e9;
      cyc(4);
      `CHK(fault_active, 1'b1)
      reactive_current = 16'sh0;
      rst();
      charging_active = 1'b1;
      cyc(25);
      charging_active = 1'b0;
      cyc(2);
      charging_active = 1'b1;
      cyc(22);
      `CHK(fault_active, 1'b0)
      cyc(15);
      `CHK(fault_active, 1'b1)
      charging_active = 1'b0;
      for (int s = 0; s < 6; s++) begin
         temp_card1_inputs = s[2:0];
         cyc(3);
         `CHK(temp_max, tmx[s])
      end
      temp_card1_inputs = 3'h3;
      temp_present = 3'h3;
      cyc(3);
      `CHK(temp_max, 16'sh7d0)
      temp_card1_inputs = 3'h1;
      temp_present = 3'h7;
      temp_short = 3'h1;
      cyc(3);
      `CHK(temp_max, -16'sh12c)
      rst();
      temp_short = 3'h0;
      temp_resp = 2'h2;
      temp_fault_limit = 16'sh12c;
      cyc(4);
      `CHK(fault_active, 1'b1)
      temp_resp = 2'h0;
      thermistor_resp = 2'h1;
      for (int y = 1; y < 3; y++) begin
         rst();
         alarm_output_style = y[1:0];
         thermistor_trip_pin = 1'b1;
         cyc(8);
         thermistor_trip_pin = 1'b0;
         cyc(20);
         `CHK(alarm_out, 1'b1)
      end
      status_reset = 1'b1;
      cyc(3);
      status_reset = 1'b0;
      cyc(3);
      `CHK(alarm_out, 1'b0)
      rst();
      alarm_output_style = 2'h1;
      thermistor_trip_pin = 1'b1;
      cyc(9880);
      `CHK(alarm_out, 1'b1)
      cyc(150);
      `CHK(alarm_out, 1'b0)
      thermistor_trip_pin = 1'b0;
      rst();
      ain1_ua = 16'h190;
      ain_min_pct = 16'h640;
      cyc(5100);
      `CHK(fault_active, 1'b0)
      rst();
      ain_min_pct = 16'h641;
      cyc(4900);
      `CHK(fault_active, 1'b0)
      cyc(200);
      `CHK(fault_active, 1'b1)
      ain_min_pct = 16'h0;
      for (int e = 0; e < 2; e++) begin
         rst();
         run_cmd = 1'b1;
         encoder_resp = 2'h3;
         speed_ref_chz = (e == 0) ? 16'hc8 : 16'h64;
         torque_avail_pmil = 16'h3e8;
         cyc(10100);
         `CHK(warning_active, e == 0)
         `CHK(open_loop_fallback, e == 0)
      end
      close_out();
   end
endmodule
`default_nettype wire
